// ### src/rssr_pkg.sv
package rssr_pkg;
   // ============================================================
   // Register indices; the byte address on the bus is the index times four
   localparam logic [7:0] IDX_MISC_STATUS = 8'h1C;
   localparam logic [7:0] IDX_SER2_SHADOW = 8'h1D;
   localparam logic [7:0] IDX_FORCE_CHG = 8'h1E;
   localparam logic [7:0] IDX_RATE_SHADOW = 8'h1F;
   localparam logic [7:0] IDX_SER1_SHADOW = 8'h20;
   localparam logic [7:0] IDX_EDGE_SEL = 8'h21;
   localparam logic [7:0] IDX_KBC_STATUS = 8'h30;
   localparam logic [7:0] IDX_INT_MASK = 8'h31;
   localparam logic [7:0] IDX_SER1_WRITE = 8'h32;
   localparam logic [7:0] IDX_SER2_WRITE = 8'h33;
   localparam logic [7:0] IDX_RATE_WRITE = 8'h34;
   localparam int ADDR_LSB = 2;
   // ============================================================
   // Field layouts and reset values
   localparam logic [7:0] MISC_STATUS_MASK = 8'h3F;
   localparam logic [7:0] FORCE_CHG_MASK = 8'h03;
   localparam logic [7:0] FORCE_CHG_RESET = 8'h03;
   localparam logic [7:0] EDGE_SEL_MASK = 8'h0F;
   localparam logic [7:0] SHADOW_RESET = 8'h00;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam int STS_PIN_SIXTY = 4;
   localparam int STS_PIN_SIXTY_ONE = 5;
   localparam int EVT_COUNT = 6;
   localparam int PIN_A_SMI = 0;
   localparam int PIN_B_SMI = 1;
   localparam int PIN_A_WAKE = 2;
   localparam int PIN_B_WAKE = 3;
   localparam int KBC_EVT = 4;
   localparam int DRV0 = 0;
   localparam int DRV1 = 1;
   // ============================================================
   // Floppy strobes, active high after inversion at the top
   typedef struct packed {
      logic step;
      logic drv0Sel;
      logic drv1Sel;
      logic diskChg;
   } rssr_floppy_t;
endpackage : rssr_pkg

// ### src/rssr_edge_det.sv
`timescale 1ns/1ps
// Two-flop synchroniser followed by a change detector for one pin
// SETTLE is the number of samples after reset before an edge may count
module rssr_edge_det #(
   parameter int SETTLE = 3
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic pin,
   output logic level,
   output logic rise,
   output logic fall
);
   logic meta;
   logic sync;
   logic prev;
   logic [SETTLE-1:0] primed;

   // ============================================================
   // Synchroniser; meta feeds only sync
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         meta <= 1'b0;
         sync <= 1'b0;
         prev <= 1'b0;
         primed <= '0;
      end else begin
         meta <= pin;
         sync <= meta;
         prev <= sync;
         primed <= {primed[SETTLE-2:0], 1'b1};
      end
   end

   // Compare each sample with the last one; gated until prev holds a real sample,
   // so a pin that idles high gives no false rise after reset
   assign level = sync;
   assign rise = primed[SETTLE-1] & sync & ~prev;
   assign fall = primed[SETTLE-1] & ~sync & prev;
endmodule : rssr_edge_det

// ### src/runtime_shadow_status_regs.sv
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
// How it works
// - Either edge of either pin sets status
// - Writing one clears edge status bits
// - Misc status bits 7:6 read zero
// - Serial two FIFO control read-only shadow
// - Serial one shadow, same layout
// - Software sets force bits, cannot clear
// - Step and drive one clears force 1
// - Step and drive zero clears force 0
// - Disk change merges selects, forces, input
// - Force bit per drive forces change
// - Force register bits 7:2 read zero
// - Floppy data-rate select read-only shadow
// - Edge bit0: pin A SMI edge choice
// - Edge bit1: pin B SMI edge choice
// - Edge bit2: pin A wake edge choice
// - Edge bit3: pin B wake edge choice
module runtime_shadow_status_regs (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic nrstMain,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic gpio_pin_sixty,
   input wire logic gpio_pin_sixty_one,
   input wire logic kbc_port_pin_a,
   input wire logic kbc_port_pin_b,
   input wire logic floppy_step_strobe_n,
   input wire logic drive_zero_select_n,
   input wire logic drive_one_select_n,
   input wire logic disk_change_input_n,
   output logic disk_change_indication,
   output logic [3:0] kbcEventPulse,
   output logic irq
);
   // ============================================================
   // Synchronised pins
   logic [3:0] pinRaw;
   logic [3:0] pinLvl;
   logic [3:0] pinRise;
   logic [3:0] pinFall;
   logic [3:0] floppyRaw;
   logic [3:0] floppyLvl;
   rssr_pkg::rssr_floppy_t fl;

   assign pinRaw = {kbc_port_pin_b, kbc_port_pin_a, gpio_pin_sixty_one, gpio_pin_sixty};
   assign floppyRaw = {~floppy_step_strobe_n, ~drive_zero_select_n,
                       ~drive_one_select_n, ~disk_change_input_n};

   // Every pin through its own rssr_edge_det instance; edges used on the four event pins, only the level on the floppy inputs
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : gPin
         rssr_edge_det uEdge (
            .mclk(mclk),
            .nrst(nrst),
            .pin(pinRaw[gi]),
            .level(pinLvl[gi]),
            .rise(pinRise[gi]),
            .fall(pinFall[gi])
         );
         rssr_edge_det uFlop (
            .mclk(mclk),
            .nrst(nrstMain),
            .pin(floppyRaw[gi]),
            .level(floppyLvl[gi]),
            .rise(),
            .fall()
         );
      end
   endgenerate
   assign fl = rssr_pkg::rssr_floppy_t'(floppyLvl);

   // ============================================================
   // APB decode; every access completes in its first access cycle
   logic [7:0] regIdx;
   logic wrEn;
   logic rdEn;
   logic [7:0] wByte;
   logic hitKnown;
   assign regIdx = paddr[9:rssr_pkg::ADDR_LSB];
   assign wrEn = psel & penable & pwrite & pready;
   assign rdEn = psel & ~penable & ~pwrite;
   assign wByte = pwdata[7:0];
   assign hitKnown = (regIdx >= rssr_pkg::IDX_MISC_STATUS && regIdx <= rssr_pkg::IDX_EDGE_SEL)
                     || (regIdx >= rssr_pkg::IDX_KBC_STATUS
                         && regIdx <= rssr_pkg::IDX_RATE_WRITE);

   // Strobes per register
   logic wrMisc;
   logic wrForce;
   logic wrEdge;
   logic wrKbc;
   logic wrMask;
   logic wrSer1;
   logic wrSer2;
   logic wrRate;
   assign wrMisc = wrEn && regIdx == rssr_pkg::IDX_MISC_STATUS;
   assign wrForce = wrEn && regIdx == rssr_pkg::IDX_FORCE_CHG;
   assign wrEdge = wrEn && regIdx == rssr_pkg::IDX_EDGE_SEL;
   assign wrKbc = wrEn && regIdx == rssr_pkg::IDX_KBC_STATUS;
   assign wrMask = wrEn && regIdx == rssr_pkg::IDX_INT_MASK;
   assign wrSer1 = wrEn && regIdx == rssr_pkg::IDX_SER1_WRITE;
   assign wrSer2 = wrEn && regIdx == rssr_pkg::IDX_SER2_WRITE;
   assign wrRate = wrEn && regIdx == rssr_pkg::IDX_RATE_WRITE;

   // ============================================================
   // Registers
   logic [7:0] miscStatus;
   logic [7:0] ser2Shadow;
   logic [7:0] ser1Shadow;
   logic [7:0] rateShadow;
   logic [7:0] forceChg;
   logic [7:0] edgeSel;
   logic [7:0] kbcStatus;
   logic [7:0] intMask;

   // Edge events for the misc status register
   logic [7:0] miscSet;
   always_comb begin
      miscSet = rssr_pkg::BYTE_ZERO;
      miscSet[rssr_pkg::STS_PIN_SIXTY] = pinRise[0] | pinFall[0];
      miscSet[rssr_pkg::STS_PIN_SIXTY_ONE] = pinRise[1] | pinFall[1];
   end

   // Keyboard-port events: falling always, rising only if both-edges chosen
   logic [3:0] kbcSet;
   assign kbcSet[rssr_pkg::PIN_A_SMI] = pinFall[2]
          | (pinRise[2] & edgeSel[rssr_pkg::PIN_A_SMI]);
   assign kbcSet[rssr_pkg::PIN_B_SMI] = pinFall[3]
          | (pinRise[3] & edgeSel[rssr_pkg::PIN_B_SMI]);
   assign kbcSet[rssr_pkg::PIN_A_WAKE] = pinFall[2]
          | (pinRise[2] & edgeSel[rssr_pkg::PIN_A_WAKE]);
   assign kbcSet[rssr_pkg::PIN_B_WAKE] = pinFall[3]
          | (pinRise[3] & edgeSel[rssr_pkg::PIN_B_WAKE]);

   // Next values; in the status registers a set in the same cycle as a clear wins, in the force bits the step clear wins
   logic [7:0] next_miscStatus;
   logic [7:0] next_kbcStatus;
   logic [7:0] next_forceChg;
   logic [7:0] kbcSetByte;
   logic [7:0] forceClr;
   assign kbcSetByte = {4'h0, kbcSet};
   assign next_miscStatus = ((miscStatus & ~(wrMisc ? wByte : rssr_pkg::BYTE_ZERO))
                             | miscSet) & rssr_pkg::MISC_STATUS_MASK;
   assign next_kbcStatus = ((kbcStatus & ~(wrKbc ? wByte : rssr_pkg::BYTE_ZERO))
                            | kbcSetByte) & rssr_pkg::EDGE_SEL_MASK;
   always_comb begin
      forceClr = rssr_pkg::BYTE_ZERO;
      forceClr[rssr_pkg::DRV1] = fl.step & fl.drv1Sel;
      forceClr[rssr_pkg::DRV0] = fl.step & fl.drv0Sel;
   end
   // Writes only ever set; a clear comes only from the step strobe
   assign next_forceChg = ((forceChg | (wrForce ? wByte : rssr_pkg::BYTE_ZERO)) & ~forceClr)
                          & rssr_pkg::FORCE_CHG_MASK;

   // Standby-domain registers
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         miscStatus <= rssr_pkg::BYTE_ZERO;
         kbcStatus <= rssr_pkg::BYTE_ZERO;
         edgeSel <= rssr_pkg::BYTE_ZERO;
         intMask <= rssr_pkg::BYTE_ZERO;
      end else begin
         miscStatus <= next_miscStatus;
         kbcStatus <= next_kbcStatus;
         if (wrEdge) edgeSel <= wByte & rssr_pkg::EDGE_SEL_MASK;
         if (wrMask) intMask <= wByte & rssr_pkg::MISC_STATUS_MASK;
      end
   end

   // Main-power registers; the force bits come up set after main reset
   always_ff @(posedge mclk or negedge nrstMain) begin
      if (!nrstMain) begin
         forceChg <= rssr_pkg::FORCE_CHG_RESET;
         ser1Shadow <= rssr_pkg::SHADOW_RESET;
         ser2Shadow <= rssr_pkg::SHADOW_RESET;
         rateShadow <= rssr_pkg::SHADOW_RESET;
      end else begin
         forceChg <= next_forceChg;
         if (wrSer1) ser1Shadow <= wByte;
         if (wrSer2) ser2Shadow <= wByte;
         if (wrRate) rateShadow <= wByte;
      end
   end

   // ============================================================
   // Disk change merge, registered so the output leaves a flop
   logic next_diskChg;
   assign next_diskChg = (fl.drv0Sel & forceChg[rssr_pkg::DRV0])
                       | (fl.drv1Sel & forceChg[rssr_pkg::DRV1])
                       | fl.diskChg;

   // Read mux; shadows are read-only, their write ports sit elsewhere
   logic [7:0] rdByte;
   always_comb begin
      unique case (regIdx)
         rssr_pkg::IDX_MISC_STATUS: rdByte = miscStatus;
         rssr_pkg::IDX_SER2_SHADOW: rdByte = ser2Shadow;
         rssr_pkg::IDX_FORCE_CHG: rdByte = forceChg & rssr_pkg::FORCE_CHG_MASK;
         rssr_pkg::IDX_RATE_SHADOW: rdByte = rateShadow;
         rssr_pkg::IDX_SER1_SHADOW: rdByte = ser1Shadow;
         rssr_pkg::IDX_EDGE_SEL: rdByte = edgeSel;
         rssr_pkg::IDX_KBC_STATUS: rdByte = kbcStatus;
         rssr_pkg::IDX_INT_MASK: rdByte = intMask;
         default: rdByte = rssr_pkg::BYTE_ZERO;
      endcase
   end

   // APB answer: ready one cycle after setup, data latched in setup
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~hitKnown;
         if (rdEn) prdata <= {24'h00_0000, rdByte};
      end
   end

   // Outputs from flops
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         disk_change_indication <= 1'b0;
         kbcEventPulse <= 4'h0;
         irq <= 1'b0;
      end else begin
         disk_change_indication <= next_diskChg;
         kbcEventPulse <= kbcSet;
         // Level irq from next state; keyboard-port status is left unmasked on purpose
         irq <= (|(next_miscStatus & intMask)) | (|next_kbcStatus[rssr_pkg::KBC_EVT-1:0]);
      end
   end

   // ============================================================
   // Assertions
   property p_edge60;
      @(posedge mclk) disable iff (!nrst)
         (pinRise[0] | pinFall[0]) |=> miscStatus[rssr_pkg::STS_PIN_SIXTY];
   endproperty
   a_edge60: assert property (p_edge60) else $error("gpio_pin_sixty edge lost");

   property p_w1c;
      @(posedge mclk) disable iff (!nrst)
         (wrMisc && wByte[rssr_pkg::STS_PIN_SIXTY] && !miscSet[rssr_pkg::STS_PIN_SIXTY])
            |=> !miscStatus[rssr_pkg::STS_PIN_SIXTY];
   endproperty
   a_w1c: assert property (p_w1c) else $error("status not cleared");

   property p_rsvd;
      @(posedge mclk) disable iff (!nrst) miscStatus[7:6] == 2'b00 && forceChg[7:2] == 6'h00;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bit set");

   property p_shadow;
      @(posedge mclk) disable iff (!nrstMain) wrSer2 |=> ser2Shadow == $past(wByte);
   endproperty
   a_shadow: assert property (p_shadow) else $error("shadow missed write");

   property p_noclr;
      @(posedge mclk) disable iff (!nrstMain)
         (forceChg[0] && !fl.step) |=> forceChg[0];
   endproperty
   a_noclr: assert property (p_noclr) else $error("force bit cleared");

   property p_stepclr;
      @(posedge mclk) disable iff (!nrstMain)
         (fl.step && fl.drv1Sel && !(wrForce && wByte[1])) |=> !forceChg[1];
   endproperty
   a_stepclr: assert property (p_stepclr) else $error("force 1 kept");

   property p_dskchg;
      @(posedge mclk) disable iff (!nrst) fl.diskChg |=> disk_change_indication;
   endproperty
   a_dskchg: assert property (p_dskchg) else $error("disk change lost");

   property p_smiA;
      @(posedge mclk) disable iff (!nrst)
         (pinRise[2] && !edgeSel[0]) |-> !kbcSet[rssr_pkg::PIN_A_SMI];
   endproperty
   a_smiA: assert property (p_smiA) else $error("rising edge taken");

   property p_edge61;
      @(posedge mclk) disable iff (!nrst)
         (pinRise[1] | pinFall[1]) |=> miscStatus[rssr_pkg::STS_PIN_SIXTY_ONE];
   endproperty
   a_edge61: assert property (p_edge61) else $error("second pin edge lost");

   property p_w0keep;
      @(posedge mclk) disable iff (!nrst)
         (wrMisc && !wByte[rssr_pkg::STS_PIN_SIXTY_ONE]
          && miscStatus[rssr_pkg::STS_PIN_SIXTY_ONE])
            |=> miscStatus[rssr_pkg::STS_PIN_SIXTY_ONE];
   endproperty
   a_w0keep: assert property (p_w0keep) else $error("zero write cleared status");

   property p_stepclr0;
      @(posedge mclk) disable iff (!nrstMain)
         (fl.step && fl.drv0Sel) |=> !forceChg[rssr_pkg::DRV0];
   endproperty
   a_stepclr0: assert property (p_stepclr0) else $error("force 0 kept");

   property p_forceSet;
      @(posedge mclk) disable iff (!nrstMain)
         (wrForce && wByte[rssr_pkg::DRV0] && !forceClr[rssr_pkg::DRV0])
            |=> forceChg[rssr_pkg::DRV0];
   endproperty
   a_forceSet: assert property (p_forceSet) else $error("force 0 not set");

   property p_shadow1;
      @(posedge mclk) disable iff (!nrstMain) wrSer1 |=> ser1Shadow == $past(wByte);
   endproperty
   a_shadow1: assert property (p_shadow1) else $error("serial one shadow missed write");

   property p_rate;
      @(posedge mclk) disable iff (!nrstMain) wrRate |=> rateShadow == $past(wByte);
   endproperty
   a_rate: assert property (p_rate) else $error("rate shadow missed write");

   property p_rdForce;
      @(posedge mclk) disable iff (!nrst)
         (rdEn && regIdx == rssr_pkg::IDX_FORCE_CHG) |=> prdata[7:2] == 6'h00;
   endproperty
   a_rdForce: assert property (p_rdForce) else $error("force reserved bits read");

   property p_rdMisc;
      @(posedge mclk) disable iff (!nrst)
         (rdEn && regIdx == rssr_pkg::IDX_MISC_STATUS) |=> prdata[7:6] == 2'b00;
   endproperty
   a_rdMisc: assert property (p_rdMisc) else $error("status reserved bits read");

   property p_force1;
      @(posedge mclk) disable iff (!nrst)
         (fl.drv1Sel && forceChg[rssr_pkg::DRV1]) |=> disk_change_indication;
   endproperty
   a_force1: assert property (p_force1) else $error("forced change 1 lost");

   property p_wakeB;
      @(posedge mclk) disable iff (!nrst)
         (pinRise[3] && edgeSel[rssr_pkg::PIN_B_WAKE]) |=> kbcStatus[rssr_pkg::PIN_B_WAKE];
   endproperty
   a_wakeB: assert property (p_wakeB) else $error("pin B wake rise lost");

   property p_smiB;
      @(posedge mclk) disable iff (!nrst)
         pinFall[3] |=> kbcStatus[rssr_pkg::PIN_B_SMI];
   endproperty
   a_smiB: assert property (p_smiB) else $error("pin B fall lost");
endmodule : runtime_shadow_status_regs

// ### bench/tb_runtime_shadow_status_regs.sv
`timescale 1ns/1ps
module tb_runtime_shadow_status_regs;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic nrstMain = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic gpA = 1'b0;
   logic gpB = 1'b0;
   logic pinA = 1'b1;
   logic pinB = 1'b1;
   logic stepN = 1'b1;
   logic sel0N = 1'b1;
   logic sel1N = 1'b1;
   logic chgN = 1'b1;
   logic diskChg;
   logic [3:0] kbcPulse;
   logic irq;
   logic [31:0] rd;
   logic er;
   logic [3:0] seen;
   int err_count = 0;
   int checks = 0;
   // Edge table: select value, pin B or A, new level, expected kbc status
   localparam int EDGE_CASES = 20;
   logic [7:0] eSel [EDGE_CASES] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h05, 8'h05, 8'h05, 8'h05,
      8'h0A, 8'h0A, 8'h0A, 8'h0A, 8'h01, 8'h01, 8'h04, 8'h04, 8'h02, 8'h02, 8'h08, 8'h08};
   logic eB [EDGE_CASES] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1,
      1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
   logic eLvl [EDGE_CASES] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1,
      1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
   logic [7:0] eExp [EDGE_CASES] = '{8'h05, 8'h00, 8'h0A, 8'h00, 8'h05, 8'h05, 8'h0A, 8'h00,
      8'h0A, 8'h0A, 8'h05, 8'h00, 8'h05, 8'h01, 8'h05, 8'h04, 8'h0A, 8'h02, 8'h0A, 8'h08};

   runtime_shadow_status_regs dut (.mclk(mclk), .nrst(nrst), .nrstMain(nrstMain),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .gpio_pin_sixty(gpA),
      .gpio_pin_sixty_one(gpB), .kbc_port_pin_a(pinA), .kbc_port_pin_b(pinB),
      .floppy_step_strobe_n(stepN), .drive_zero_select_n(sel0N),
      .drive_one_select_n(sel1N), .disk_change_input_n(chgN),
      .disk_change_indication(diskChg), .kbcEventPulse(kbcPulse), .irq(irq));

   // ============================================================
   // Clock and shared tasks
   always #5 mclk = ~mclk;

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : tally_and_finish

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk

   task automatic wt(input int n);
      repeat (n) @(posedge mclk);
   endtask : wt

   // One APB transfer; holds the request until pready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {24'h00_0000, wd};
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // A lost answer ends the run here; otherwise one idle cycle follows
      if (n >= 20) begin
         err_count++;
         $display("mismatch at %0t: no pready", $time);
         tally_and_finish();
      end else begin
         @(posedge mclk);
      end
   endtask : apb

   task automatic rdc(input logic [7:0] idx, input logic [31:0] e);
      apb(1'b0, idx, 8'h00);
      chk(rd, e);
   endtask : rdc

   // ============================================================
   // Main sequence
   initial begin
      wt(10);
      nrst <= 1'b1;
      nrstMain <= 1'b1;
      wt(2);
      rdc(rssr_pkg::IDX_FORCE_CHG, 32'h0000_0003);
      rdc(rssr_pkg::IDX_EDGE_SEL, 32'h0000_0000);
      rdc(rssr_pkg::IDX_MISC_STATUS, 32'h0000_0000);
      $display("test reset done");
      // Shadows follow their write ports; shadow places refuse writes
      apb(1'b1, rssr_pkg::IDX_SER1_WRITE, 8'hC9);
      apb(1'b1, rssr_pkg::IDX_SER2_WRITE, 8'h4E);
      apb(1'b1, rssr_pkg::IDX_RATE_WRITE, 8'hB7);
      apb(1'b1, rssr_pkg::IDX_SER1_SHADOW, 8'h00);
      apb(1'b1, rssr_pkg::IDX_RATE_SHADOW, 8'h00);
      rdc(rssr_pkg::IDX_SER1_SHADOW, 32'h0000_00C9);
      rdc(rssr_pkg::IDX_SER2_SHADOW, 32'h0000_004E);
      rdc(rssr_pkg::IDX_RATE_SHADOW, 32'h0000_00B7);
      apb(1'b0, 8'h3F, 8'h00);
      chk({31'h0, er}, 32'h0000_0001);
      chk(rd, 32'h0000_0000);
      $display("test shadows done");
      // Either edge of each pin sets its status bit; a pulse is one event pair
      gpA <= 1'b1;
      wt(6);
      rdc(rssr_pkg::IDX_MISC_STATUS, 32'h0000_0010);
      gpB <= 1'b1;
      wt(6);
      gpB <= 1'b0;
      wt(6);
      rdc(rssr_pkg::IDX_MISC_STATUS, 32'h0000_0030);
      chk({31'h0, irq}, 32'h0000_0000);
      apb(1'b1, rssr_pkg::IDX_INT_MASK, 8'h20);
      wt(2);
      chk({31'h0, irq}, 32'h0000_0001);
      apb(1'b1, rssr_pkg::IDX_MISC_STATUS, 8'h10);
      apb(1'b1, rssr_pkg::IDX_MISC_STATUS, 8'h00);
      rdc(rssr_pkg::IDX_MISC_STATUS, 32'h0000_0020);
      apb(1'b1, rssr_pkg::IDX_MISC_STATUS, 8'hFF);
      rdc(rssr_pkg::IDX_MISC_STATUS, 32'h0000_0000);
      wt(2);
      chk({31'h0, irq}, 32'h0000_0000);
      $display("test misc status done");
      // Forced change per drive, cleared by a step while that drive is selected
      wt(4);
      chk({31'h0, diskChg}, 32'h0000_0000);
      sel0N <= 1'b0;
      wt(8);
      chk({31'h0, diskChg}, 32'h0000_0001);
      stepN <= 1'b0;
      wt(4);
      stepN <= 1'b1;
      wt(8);
      rdc(rssr_pkg::IDX_FORCE_CHG, 32'h0000_0002);
      chk({31'h0, diskChg}, 32'h0000_0000);
      apb(1'b1, rssr_pkg::IDX_FORCE_CHG, 8'h00);
      rdc(rssr_pkg::IDX_FORCE_CHG, 32'h0000_0002);
      sel0N <= 1'b1;
      sel1N <= 1'b0;
      wt(8);
      chk({31'h0, diskChg}, 32'h0000_0001);
      stepN <= 1'b0;
      wt(4);
      stepN <= 1'b1;
      sel1N <= 1'b1;
      wt(8);
      rdc(rssr_pkg::IDX_FORCE_CHG, 32'h0000_0000);
      apb(1'b1, rssr_pkg::IDX_FORCE_CHG, 8'h01);
      rdc(rssr_pkg::IDX_FORCE_CHG, 32'h0000_0001);
      // Main reset alone restores the force bits and clears the shadows
      nrstMain <= 1'b0;
      wt(2);
      nrstMain <= 1'b1;
      wt(2);
      rdc(rssr_pkg::IDX_FORCE_CHG, 32'h0000_0003);
      rdc(rssr_pkg::IDX_SER1_SHADOW, 32'h0000_0000);
      rdc(rssr_pkg::IDX_INT_MASK, 32'h0000_0020);
      apb(1'b1, rssr_pkg::IDX_FORCE_CHG, 8'hFF);
      rdc(rssr_pkg::IDX_FORCE_CHG, 32'h0000_0003);
      chgN <= 1'b0;
      wt(8);
      chk({31'h0, diskChg}, 32'h0000_0001);
      chgN <= 1'b1;
      $display("test force change done");
      // Falling edge always counts; rising only where the select bit is one
      apb(1'b1, rssr_pkg::IDX_EDGE_SEL, 8'hFF);
      rdc(rssr_pkg::IDX_EDGE_SEL, 32'h0000_000F);
      for (int i = 0; i < EDGE_CASES; i++) begin
         apb(1'b1, rssr_pkg::IDX_EDGE_SEL, eSel[i]);
         if (eB[i]) begin
            pinB <= eLvl[i];
         end else begin
            pinA <= eLvl[i];
         end
         // Collect the one-cycle event pulses while the edge travels through
         seen = 4'h0;
         repeat (6) begin
            @(posedge mclk);
            seen = seen | kbcPulse;
         end
         chk({28'h000_0000, seen}, {28'h000_0000, eExp[i][3:0]});
         rdc(rssr_pkg::IDX_KBC_STATUS, {24'h00_0000, eExp[i]});
         chk({31'h0, irq}, {31'h0, eExp[i] != 8'h00});
         apb(1'b1, rssr_pkg::IDX_KBC_STATUS, 8'h0F);
      end
      rdc(rssr_pkg::IDX_KBC_STATUS, 32'h0000_0000);
      $display("test edge select done");
      tally_and_finish();
   end
endmodule : tb_runtime_shadow_status_regs
